// [core/cbrl_consts.vh]
// constants for the configuration byte reset loader
`ifndef CBRL_CONSTS_VH
`define CBRL_CONSTS_VH

// command codes on the programmer and self-programming ports
`define CBRL_CMD_READ        2'h0
`define CBRL_CMD_PROG        2'h1
`define CBRL_CMD_ERASE       2'h2
`define CBRL_CMD_CHIP_ERASE  2'h3

// byte selects inside the configuration space
`define CBRL_SEL_BOOTSEC     1'b0
`define CBRL_SEL_BROWNOUT    1'b1

// address spaces of a programmer access
`define CBRL_SPACE_CODE      1'b0
`define CBRL_SPACE_CFG       1'b1

// field positions, boot and security byte
`define CBRL_BOOT_SRC_BIT    7
`define CBRL_TBL_LOCK_BIT    2
`define CBRL_CHIP_LOCK_BIT   1

// field positions, brownout byte
`define CBRL_BOD_EN_BIT      7
`define CBRL_BOD_LVL_HI_BIT  6
`define CBRL_BOD_LVL_LO_BIT  5
`define CBRL_BOD_RST_BIT     4

// erased value and the value shown for a locked code byte
`define CBRL_BLANK_BYTE      8'hff
`define CBRL_LOCKED_READ     8'hff

// reset values of the live bits before the first load
`define CBRL_LIVE_BOOT_RST   1'b0
`define CBRL_LIVE_BOD_RST    4'hf
`define CBRL_LIVE_TLOCK_RST  1'b1

`endif

// [core/cbrl_nv_store.v]
// non-volatile store holding the two configuration bytes
`timescale 1ns/10ps
`default_nettype none
`include "cbrl_consts.vh"

module cbrl_nv_store #(
    parameter NUM_BYTES = 2
) (
    // clock
    input  wire       ref_clk,
    // byte access
    input  wire       prog_en,
    input  wire       erase_en,
    input  wire       wr_sel,
    input  wire [7:0] wr_data,
    // whole chip erase
    input  wire       chip_erase_en,
    // contents, read without delay
    output wire [7:0] bootsec_byte,
    output wire [7:0] brownout_byte
);

    reg [7:0] cell_mem [0:NUM_BYTES-1];
    integer   i;

    // cells power up erased; no reset because contents survive every reset
    initial
    begin
        for (i = 0; i < NUM_BYTES; i = i + 1)
            cell_mem[i] = `CBRL_BLANK_BYTE;
    end

    // programming only clears bits, erase sets them back to ones
    always @(posedge ref_clk)
    begin
        if (chip_erase_en)
        begin
            for (i = 0; i < NUM_BYTES; i = i + 1)
                cell_mem[i] <= `CBRL_BLANK_BYTE;
        end
        else if (erase_en)
            cell_mem[wr_sel] <= `CBRL_BLANK_BYTE;
        else if (prog_en)
            cell_mem[wr_sel] <= cell_mem[wr_sel] & wr_data;
    end

    assign bootsec_byte  = cell_mem[`CBRL_SEL_BOOTSEC];
    assign brownout_byte = cell_mem[`CBRL_SEL_BROWNOUT];

endmodule // cbrl_nv_store

`default_nettype wire

// [core/cbrl_top.v]
// configuration byte store, reset reload of live bits and read protection
//
// Notes on behaviour
// - after reset copy config bits with live counterparts into live bits
// - software reset reloads everything except the live boot select bit
// - boot source bit 7: one picks application area, zero the loader area
// - table lock zero blocks external-code table reads of internal areas
// - chip lock zero makes programmer code reads return ff
// - configuration bytes are always readable, locked or not
// - locked chip refuses config byte program or erase; chip erase clears all
// - chip lock does not change self-programming behaviour
// - brownout byte bit 7 enables brownout detection
// - brownout bits 6 and 5 select one of four threshold levels
// - brownout bit 4 lets a brownout event cause reset
// - non-software reset loads live boot select with inverted boot bit
`timescale 1ns/10ps
`default_nettype none
`include "cbrl_consts.vh"

module cbrl_top #(
    parameter NUM_CFG_BYTES = 2
) (
    // clock and power-on reset
    input  wire       ref_clk,
    input  wire       rst,
    // system reset sequencing
    input  wire       sys_rst_hold,
    input  wire       sw_reset_cause,
    output reg        cpu_hold_reg,
    // parallel programmer port
    input  wire       pgm_req,
    input  wire [1:0] pgm_cmd,
    input  wire       pgm_space,
    input  wire       pgm_sel,
    input  wire [7:0] pgm_wdata,
    input  wire [7:0] code_mem_rdata,
    output reg        pgm_ack_reg,
    output reg        pgm_refused_reg,
    output reg  [7:0] pgm_rdata_reg,
    output reg        code_erase_reg,
    // self-programming port
    input  wire       isp_req,
    input  wire [1:0] isp_cmd,
    input  wire       isp_sel,
    input  wire [7:0] isp_wdata,
    output reg        isp_ack_reg,
    output reg        isp_refused_reg,
    output reg  [7:0] isp_rdata_reg,
    // live control bits written by software
    input  wire       sfr_boot_wr,
    input  wire       sfr_boot_wdata,
    input  wire       sfr_bod_wr,
    input  wire [7:0] sfr_bod_wdata,
    // live control outputs
    output reg        live_boot_select_reg,
    output reg        boot_from_loader_reg,
    output reg        table_read_lock_reg,
    output reg        brownout_detect_en_reg,
    output reg  [1:0] brownout_level_reg,
    output reg        brownout_reset_en_reg,
    // table read gate
    input  wire       tbl_rd_req,
    input  wire       tbl_rd_from_external,
    output reg        tbl_rd_allow_reg,
    output reg        tbl_rd_blocked_reg
);

    // reset sequencer states
    localparam [1:0] ST_LOAD = 2'h0;
    localparam [1:0] ST_HOLD = 2'h1;
    localparam [1:0] ST_RUN  = 2'h2;

    // live brownout bits before the first load: enable, level hi, level lo, reset enable
    localparam [3:0] LIVE_BOD_RST = `CBRL_LIVE_BOD_RST;

    reg  [1:0] state_reg;
    reg  [1:0] state_next;
    reg        sw_cause_reg;
    wire [7:0] bootsec_byte;
    wire [7:0] brownout_byte;
    wire       chip_locked;

    // locked when the chip lock bit is programmed to zero
    assign chip_locked = ~bootsec_byte[`CBRL_CHIP_LOCK_BIT];

    // a config byte change by either port; locked chip refuses programmer ones
    function cfg_change_ok;
        input       req;
        input [1:0] cmd;
        input       space;
        input       lock_applies;
        begin
            cfg_change_ok = req && (space == `CBRL_SPACE_CFG) &&
                            ((cmd == `CBRL_CMD_PROG) || (cmd == `CBRL_CMD_ERASE)) &&
                            !lock_applies;
        end
    endfunction

    wire pgm_chip_erase;
    wire pgm_cfg_ok;
    wire pgm_cfg_refuse;
    wire isp_taken;
    wire isp_cfg_ok;
    reg  nv_prog_en;
    reg  nv_erase_en;
    reg  nv_sel;
    reg  [7:0] nv_wdata;

    assign pgm_chip_erase = pgm_req && (pgm_cmd == `CBRL_CMD_CHIP_ERASE);
    assign pgm_cfg_ok     = cfg_change_ok(pgm_req, pgm_cmd, pgm_space, chip_locked);
    assign pgm_cfg_refuse = cfg_change_ok(pgm_req, pgm_cmd, pgm_space, 1'b0) && chip_locked;
    // programmer wins a same-cycle clash; the self-programming request is refused
    assign isp_taken      = isp_req && !pgm_req;
    // lock never enters the self-programming path
    assign isp_cfg_ok     = cfg_change_ok(isp_taken, isp_cmd, `CBRL_SPACE_CFG, 1'b0);

    // steer the single write path of the store
    always @*
    begin
        nv_prog_en  = 1'b0;
        nv_erase_en = 1'b0;
        nv_sel      = pgm_sel;
        nv_wdata    = pgm_wdata;
        if (pgm_cfg_ok)
        begin
            nv_prog_en  = (pgm_cmd == `CBRL_CMD_PROG);
            nv_erase_en = (pgm_cmd == `CBRL_CMD_ERASE);
        end
        else if (isp_cfg_ok)
        begin
            nv_sel      = isp_sel;
            nv_wdata    = isp_wdata;
            nv_prog_en  = (isp_cmd == `CBRL_CMD_PROG);
            nv_erase_en = (isp_cmd == `CBRL_CMD_ERASE);
        end
    end

    cbrl_nv_store #(
        .NUM_BYTES     (NUM_CFG_BYTES)
    ) u_store (
        .ref_clk       (ref_clk),
        .prog_en       (nv_prog_en),
        .erase_en      (nv_erase_en),
        .wr_sel        (nv_sel),
        .wr_data       (nv_wdata),
        .chip_erase_en (pgm_chip_erase),
        .bootsec_byte  (bootsec_byte),
        .brownout_byte (brownout_byte)
    );

    // programmer answers one cycle after the request
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            pgm_ack_reg     <= 1'b0;
            pgm_refused_reg <= 1'b0;
            pgm_rdata_reg   <= `CBRL_BLANK_BYTE;
            code_erase_reg  <= 1'b0;
        end
        else
        begin
            pgm_ack_reg     <= pgm_req;
            pgm_refused_reg <= pgm_cfg_refuse;
            code_erase_reg  <= pgm_chip_erase;
            if (pgm_req && (pgm_cmd == `CBRL_CMD_READ))
            begin
                if (pgm_space == `CBRL_SPACE_CFG)
                    // config bytes never masked by the lock
                    pgm_rdata_reg <= pgm_sel ? brownout_byte : bootsec_byte;
                else if (chip_locked)
                    pgm_rdata_reg <= `CBRL_LOCKED_READ;
                else
                    pgm_rdata_reg <= code_mem_rdata;
            end
        end
    end

    // self-programming answers, identical locked or not
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            isp_ack_reg     <= 1'b0;
            isp_refused_reg <= 1'b0;
            isp_rdata_reg   <= `CBRL_BLANK_BYTE;
        end
        else
        begin
            isp_ack_reg     <= isp_taken;
            isp_refused_reg <= isp_req && pgm_req;
            if (isp_taken && (isp_cmd == `CBRL_CMD_READ))
                isp_rdata_reg <= isp_sel ? brownout_byte : bootsec_byte;
        end
    end

    // next state of the reset sequencer
    always @*
    begin
        case (state_reg)
            ST_LOAD:
                state_next = ST_HOLD;
            ST_HOLD:
                state_next = sys_rst_hold ? ST_HOLD : ST_RUN;
            ST_RUN:
                state_next = sys_rst_hold ? ST_LOAD : ST_RUN;
            default:
                state_next = ST_LOAD;
        endcase
    end

    // cause of the reset is caught on its leading edge, power-on counts as hardware
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg    <= ST_LOAD;
            sw_cause_reg <= 1'b0;
            cpu_hold_reg <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            if (state_reg == ST_RUN && sys_rst_hold)
                sw_cause_reg <= sw_reset_cause;
            // cpu stays held until the load is done and reset has gone away
            cpu_hold_reg <= (state_next != ST_RUN);
        end
    end

    // live bits: loaded in the load state, otherwise software may change all but the table lock
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            live_boot_select_reg   <= `CBRL_LIVE_BOOT_RST;
            table_read_lock_reg    <= `CBRL_LIVE_TLOCK_RST;
            brownout_detect_en_reg <= LIVE_BOD_RST[3];
            brownout_level_reg     <= LIVE_BOD_RST[2:1];
            brownout_reset_en_reg  <= LIVE_BOD_RST[0];
        end
        else if (state_reg == ST_LOAD)
        begin
            // software reset keeps the boot selection software chose
            if (!sw_cause_reg)
                live_boot_select_reg <= ~bootsec_byte[`CBRL_BOOT_SRC_BIT];
            table_read_lock_reg    <= bootsec_byte[`CBRL_TBL_LOCK_BIT];
            brownout_detect_en_reg <= brownout_byte[`CBRL_BOD_EN_BIT];
            brownout_level_reg     <= {brownout_byte[`CBRL_BOD_LVL_HI_BIT],
                                       brownout_byte[`CBRL_BOD_LVL_LO_BIT]};
            brownout_reset_en_reg  <= brownout_byte[`CBRL_BOD_RST_BIT];
        end
        else
        begin
            if (sfr_boot_wr)
                live_boot_select_reg <= sfr_boot_wdata;
            if (sfr_bod_wr)
            begin
                brownout_detect_en_reg <= sfr_bod_wdata[`CBRL_BOD_EN_BIT];
                brownout_level_reg     <= {sfr_bod_wdata[`CBRL_BOD_LVL_HI_BIT],
                                           sfr_bod_wdata[`CBRL_BOD_LVL_LO_BIT]};
                brownout_reset_en_reg  <= sfr_bod_wdata[`CBRL_BOD_RST_BIT];
            end
        end
    end

    // boot area latched as the cpu is released; later writes only affect the next boot
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            boot_from_loader_reg <= 1'b0;
        else if (state_reg == ST_HOLD && !sys_rst_hold)
            boot_from_loader_reg <= live_boot_select_reg;
    end

    // table read gate, answer one cycle after the request
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            tbl_rd_allow_reg   <= 1'b0;
            tbl_rd_blocked_reg <= 1'b0;
        end
        else
        begin
            tbl_rd_allow_reg   <= tbl_rd_req &&
                                  !(tbl_rd_from_external && !table_read_lock_reg);
            tbl_rd_blocked_reg <= tbl_rd_req && tbl_rd_from_external &&
                                  !table_read_lock_reg;
        end
    end

endmodule // cbrl_top

`default_nettype wire

// [core/cbrl_top_unused_placeholder_none.v]
// intentionally empty of logic: no additional module
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// [verif/cbrl_checker.sv]
// port assertions for the configuration byte reset loader
`timescale 1ns/10ps
`default_nettype none
`include "cbrl_consts.vh"

module cbrl_checker (
    // clock and reset sequencing
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       sys_rst_hold,
    input wire logic       cpu_hold_reg,
    // programmer and self-programming ports
    input wire logic       pgm_req,
    input wire logic [1:0] pgm_cmd,
    input wire logic       pgm_space,
    input wire logic [7:0] code_mem_rdata,
    input wire logic       pgm_refused_reg,
    input wire logic [7:0] pgm_rdata_reg,
    input wire logic       code_erase_reg,
    input wire logic       isp_req,
    input wire logic       isp_ack_reg,
    input wire logic       isp_refused_reg,
    // live bits and table read gate
    input wire logic       sfr_boot_wr,
    input wire logic       live_boot_select_reg,
    input wire logic       table_read_lock_reg,
    input wire logic       tbl_rd_req,
    input wire logic       tbl_rd_from_external,
    input wire logic       tbl_rd_allow_reg,
    input wire logic       tbl_rd_blocked_reg
);
    // single domain, so clock and reset are named once
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_code_read_mask: assert property (
        pgm_req && pgm_cmd == `CBRL_CMD_READ && pgm_space == `CBRL_SPACE_CODE |=>
        pgm_rdata_reg == `CBRL_LOCKED_READ || pgm_rdata_reg == $past(code_mem_rdata))
        else $error("code read gave neither ff nor the array byte");
    a_refuse_cfg_only: assert property (
        pgm_refused_reg |-> $past(pgm_req && pgm_space == `CBRL_SPACE_CFG
        && (pgm_cmd == `CBRL_CMD_PROG || pgm_cmd == `CBRL_CMD_ERASE)))
        else $error("refusal without a config program or erase");
    a_chip_erase_taken: assert property (
        pgm_req && pgm_cmd == `CBRL_CMD_CHIP_ERASE |=> code_erase_reg && !pgm_refused_reg)
        else $error("chip erase not carried out");
    a_isp_lock_free: assert property (
        isp_req && !pgm_req |=> isp_ack_reg && !isp_refused_reg)
        else $error("self-programming request not acknowledged");
    a_table_read_block: assert property (
        tbl_rd_req && tbl_rd_from_external && !table_read_lock_reg |=>
        tbl_rd_blocked_reg && !tbl_rd_allow_reg)
        else $error("external table read not blocked");
    a_table_read_free: assert property (
        tbl_rd_req && (!tbl_rd_from_external || table_read_lock_reg) |=>
        tbl_rd_allow_reg && !tbl_rd_blocked_reg)
        else $error("table read wrongly blocked");
    a_cpu_held_reload: assert property (
        sys_rst_hold [*3] |-> cpu_hold_reg)
        else $error("cpu released while reset still held");
    a_live_boot_keep: assert property (
        !cpu_hold_reg && !sfr_boot_wr && !sys_rst_hold |=> $stable(live_boot_select_reg))
        else $error("live boot select moved without a write");
endmodule // cbrl_checker

bind cbrl_top cbrl_checker u_cbrl_checker (
    .ref_clk, .rst, .sys_rst_hold, .cpu_hold_reg, .pgm_req, .pgm_cmd, .pgm_space,
    .code_mem_rdata, .pgm_refused_reg, .pgm_rdata_reg, .code_erase_reg, .isp_req,
    .isp_ack_reg, .isp_refused_reg, .sfr_boot_wr, .live_boot_select_reg,
    .table_read_lock_reg, .tbl_rd_req, .tbl_rd_from_external, .tbl_rd_allow_reg,
    .tbl_rd_blocked_reg
);
`default_nettype wire

// [verif/cbrl_prog_model.sv]
// programmer and self-programming firmware driving the byte ports
`timescale 1ns/10ps
`default_nettype none

module cbrl_prog_model (
    // clock
    input  wire logic       ref_clk,
    // request lines, command fields shared by both ports
    output var  logic       pgm_req,
    output var  logic       isp_req,
    output var  logic [1:0] cmd,
    output var  logic       space,
    output var  logic       sel,
    output var  logic [7:0] wdata
);
    // idle at time zero
    initial
    begin
        {pgm_req, isp_req, cmd, space, sel} = 6'h00;
        wdata = 8'hff;
    end

    // one request held over exactly one taken edge
    task op(input logic i, input logic [1:0] c, input logic s, input logic b,
            input logic [7:0] d);
    begin
        @(posedge ref_clk);
        #1;
        {cmd, space, sel, wdata} = {c, s, b, d};
        pgm_req = !i;
        isp_req = i;
        @(posedge ref_clk);
        #1;
        {pgm_req, isp_req} = 2'h0;
        // released data must not look like the last value
        wdata = ~d;
    end
    endtask
endmodule // cbrl_prog_model
`default_nettype wire

// [verif/cbrl_top_tb.sv]
// self-checking bench for the configuration byte reset loader
`timescale 1ns/10ps
`default_nettype none
`include "cbrl_consts.vh"

module cbrl_top_tb;
    logic       ref_clk = 1'b0;
    logic       rst = 1'b1;
    logic       sys_rst_hold = 1'b0;
    logic       sw_reset_cause = 1'b0;
    logic [7:0] code_mem_rdata = 8'h5a;
    logic       sfr_boot_wr = 1'b0;
    logic       sfr_boot_wdata = 1'b0;
    logic       sfr_bod_wr = 1'b0;
    logic [7:0] sfr_bod_wdata = 8'h00;
    logic       tbl_rd_req = 1'b0;
    logic       tbl_rd_from_external = 1'b0;
    wire        pgm_req, isp_req, space, sel, cpu_hold_reg, pgm_ack_reg, pgm_refused_reg;
    wire        code_erase_reg, isp_ack_reg, isp_refused_reg, live_boot_select_reg;
    wire        boot_from_loader_reg, table_read_lock_reg, brownout_detect_en_reg;
    wire        brownout_reset_en_reg, tbl_rd_allow_reg, tbl_rd_blocked_reg;
    wire [1:0]  cmd, brownout_level_reg;
    wire [7:0]  wdata, pgm_rdata_reg, isp_rdata_reg;
    wire [5:0]  live = {live_boot_select_reg, table_read_lock_reg, brownout_detect_en_reg,
                        brownout_level_reg, brownout_reset_en_reg};
    integer     fail_count = 0;
    integer     comparisons = 0;

    // 20 MHz system clock
    always #25 ref_clk = ~ref_clk;

    cbrl_top u_cbrl_top (
        .ref_clk, .rst, .sys_rst_hold, .sw_reset_cause, .cpu_hold_reg, .pgm_req,
        .pgm_cmd(cmd), .pgm_space(space), .pgm_sel(sel), .pgm_wdata(wdata),
        .code_mem_rdata, .pgm_ack_reg, .pgm_refused_reg, .pgm_rdata_reg, .code_erase_reg,
        .isp_req, .isp_cmd(cmd), .isp_sel(sel), .isp_wdata(wdata), .isp_ack_reg,
        .isp_refused_reg, .isp_rdata_reg, .sfr_boot_wr, .sfr_boot_wdata, .sfr_bod_wr,
        .sfr_bod_wdata, .live_boot_select_reg, .boot_from_loader_reg, .table_read_lock_reg,
        .brownout_detect_en_reg, .brownout_level_reg, .brownout_reset_en_reg, .tbl_rd_req,
        .tbl_rd_from_external, .tbl_rd_allow_reg, .tbl_rd_blocked_reg
    );

    cbrl_prog_model u_cbrl_prog_model (
        .ref_clk, .pgm_req, .isp_req, .cmd, .space, .sel, .wdata
    );

    task chk(input logic [7:0] seen, input logic [7:0] exp);
    begin
        comparisons = comparisons + 1;
        if (seen !== exp)
        begin
            fail_count = fail_count + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    end
    endtask

    task close_out;
    begin
        if (fail_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask

    task pg(input logic i, input logic [1:0] c, input logic s, input logic b,
            input logic [7:0] d);
        u_cbrl_prog_model.op(i, c, s, b, d);
    endtask

    // one table read; exp holds allow then blocked
    task tbl(input logic e, input logic [7:0] exp);
    begin
        @(posedge ref_clk);
        #1;
        tbl_rd_req = 1'b1;
        tbl_rd_from_external = e;
        @(posedge ref_clk);
        #1;
        tbl_rd_req = 1'b0;
        chk({tbl_rd_allow_reg, tbl_rd_blocked_reg}, exp);
    end
    endtask

    // chip reset held over three edges, then released
    task rst_seq(input logic sw);
    begin
        @(posedge ref_clk);
        #1;
        sys_rst_hold = 1'b1;
        sw_reset_cause = sw;
        repeat (3) @(posedge ref_clk);
        #1;
        chk(cpu_hold_reg, 8'h01);
        sys_rst_hold = 1'b0;
        sw_reset_cause = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        chk(cpu_hold_reg, 8'h00);
    end
    endtask

    // hang guard, far beyond the well under a hundred cycles the run needs
    initial
    begin
        #100000;
        fail_count = fail_count + 1;
        close_out;
    end

    // main sequence
    initial
    begin
        repeat (10) @(posedge ref_clk);
        chk(cpu_hold_reg, 8'h01);
        chk(live, 8'h1f);
        #1;
        rst = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        chk(cpu_hold_reg, 8'h00);
        chk(live, 8'h1f);
        chk(boot_from_loader_reg, 8'h00);
        pg(0, `CBRL_CMD_READ, `CBRL_SPACE_CFG, `CBRL_SEL_BOOTSEC, 8'h00);
        chk(pgm_ack_reg, 8'h01);
        chk(pgm_rdata_reg, `CBRL_BLANK_BYTE);
        pg(0, `CBRL_CMD_READ, `CBRL_SPACE_CODE, 1'b0, 8'h00);
        chk(pgm_rdata_reg, 8'h5a);
        pg(0, `CBRL_CMD_PROG, `CBRL_SPACE_CFG, `CBRL_SEL_BROWNOUT, 8'h2f);
        pg(0, `CBRL_CMD_PROG, `CBRL_SPACE_CFG, `CBRL_SEL_BOOTSEC, 8'h79);
        pg(0, `CBRL_CMD_READ, `CBRL_SPACE_CODE, 1'b0, 8'h00);
        chk(pgm_rdata_reg, `CBRL_LOCKED_READ);
        pg(0, `CBRL_CMD_READ, `CBRL_SPACE_CFG, `CBRL_SEL_BOOTSEC, 8'h00);
        chk(pgm_rdata_reg, 8'h79);
        pg(0, `CBRL_CMD_ERASE, `CBRL_SPACE_CFG, `CBRL_SEL_BROWNOUT, 8'h00);
        chk(pgm_refused_reg, 8'h01);
        pg(0, `CBRL_CMD_READ, `CBRL_SPACE_CFG, `CBRL_SEL_BROWNOUT, 8'h00);
        chk(pgm_rdata_reg, 8'h2f);
        pg(1, `CBRL_CMD_ERASE, `CBRL_SPACE_CFG, `CBRL_SEL_BROWNOUT, 8'h00);
        chk({isp_ack_reg, isp_refused_reg}, 8'h02);
        pg(1, `CBRL_CMD_PROG, `CBRL_SPACE_CFG, `CBRL_SEL_BROWNOUT, 8'h4f);
        pg(1, `CBRL_CMD_READ, `CBRL_SPACE_CFG, `CBRL_SEL_BROWNOUT, 8'h00);
        chk(isp_rdata_reg, 8'h4f);
        tbl(1'b1, 8'h02);
        rst_seq(1'b0);
        chk(live, 8'h24);
        chk(boot_from_loader_reg, 8'h01);
        tbl(1'b1, 8'h01);
        tbl(1'b0, 8'h02);
        // software takes over the live boot select and brownout bits
        @(posedge ref_clk);
        #1;
        {sfr_boot_wr, sfr_boot_wdata, sfr_bod_wr, sfr_bod_wdata} = {3'h5, 8'hf0};
        @(posedge ref_clk);
        #1;
        {sfr_boot_wr, sfr_bod_wr} = 2'h0;
        chk(live, 8'h0f);
        rst_seq(1'b1);
        chk(live, 8'h04);
        chk(boot_from_loader_reg, 8'h00);
        pg(0, `CBRL_CMD_CHIP_ERASE, `CBRL_SPACE_CFG, 1'b0, 8'h00);
        chk({code_erase_reg, pgm_refused_reg}, 8'h02);
        pg(0, `CBRL_CMD_READ, `CBRL_SPACE_CFG, `CBRL_SEL_BOOTSEC, 8'h00);
        chk(pgm_rdata_reg, `CBRL_BLANK_BYTE);
        pg(0, `CBRL_CMD_READ, `CBRL_SPACE_CFG, `CBRL_SEL_BROWNOUT, 8'h00);
        chk(pgm_rdata_reg, `CBRL_BLANK_BYTE);
        pg(0, `CBRL_CMD_READ, `CBRL_SPACE_CODE, 1'b0, 8'h00);
        chk(pgm_rdata_reg, 8'h5a);
        close_out;
    end
endmodule // cbrl_top_tb
`default_nettype wire
